/* src/pack_cfg_pkg.sv */
// package: register map, field layout, reset values and load sequencer states of the pack setup bank
package pack_cfg_pkg;

	// =====================================================================
	// register byte addresses (one aligned word each)
	// =====================================================================
	localparam logic [7:0]  ADDR_MAIN    = 8'h00;
	localparam logic [7:0]  ADDR_SECOND  = 8'h04;
	localparam logic [7:0]  ADDR_THIRD   = 8'h08;
	localparam logic [7:0]  ADDR_DIVIDER = 8'h0c;
	localparam logic [7:0]  ADDR_CELLS   = 8'h10;
	localparam logic [7:0]  ADDR_CTRL    = 8'h14;
	localparam logic [7:0]  ADDR_STATUS  = 8'h18;

	// =====================================================================
	// stored image: word indices, reset values, writable masks
	// =====================================================================
	localparam int          NV_WORDS     = 5;
	localparam logic [2:0]  IDX_MAIN     = 3'h0;
	localparam logic [2:0]  IDX_SECOND   = 3'h1;
	localparam logic [2:0]  IDX_THIRD    = 3'h2;
	localparam logic [2:0]  IDX_DIVIDER  = 3'h3;
	localparam logic [2:0]  IDX_CELLS    = 3'h4;
	localparam logic [2:0]  IDX_LAST     = 3'h4;
	localparam logic [15:0] RST_MAIN     = 16'h0131;
	localparam logic [15:0] RST_SECOND   = 16'h00a3;
	localparam logic [15:0] RST_THIRD    = 16'h0000;
	localparam logic [15:0] RST_DIVIDER  = 16'h1388;
	localparam logic [15:0] RST_CELLS    = 16'h0001;
	localparam logic [15:0] MASK_MAIN    = 16'hcff1;
	localparam logic [15:0] MASK_SECOND  = 16'h00af;
	localparam logic [15:0] MASK_THIRD   = 16'h00ff;
	localparam logic [15:0] MASK_DIVIDER = 16'hffff;
	localparam logic [15:0] MASK_CELLS   = 16'h00ff;
	localparam logic [7:0]  SUBCLASS_ID  = 8'h40;

	// =====================================================================
	// field positions
	// =====================================================================
	localparam int B_RESERVE_NOLOAD_COMP    = 15;
	localparam int B_CAL_PERM  = 14;
	localparam int B_DIV_SEL   = 11;
	localparam int B_WAKE_EN   = 10;
	localparam int B_WAKE_HI   = 9;
	localparam int B_WAKE_LO   = 8;
	localparam int B_TENFOLD   = 7;
	localparam int B_RES_STEP  = 6;
	localparam int B_SLEEP     = 5;
	localparam int B_RELOAD    = 4;
	localparam int B_THERM     = 0;
	localparam int B_CHG_DOD   = 7;
	localparam int B_VCONS     = 5;
	localparam int B_TEMP_ZONE = 3;
	localparam int B_LFP_REST  = 2;
	localparam int B_DOD_WT    = 1;
	localparam int B_FAST_CONV = 0;
	localparam int B_HEALTH    = 7;
	localparam int B_HOLD      = 6;
	localparam int B_NEAR_END  = 5;
	localparam int B_SLP_FAST  = 4;
	localparam int B_LOCK_ZERO = 3;
	localparam int B_JUMP      = 2;
	localparam int B_RSMOOTH   = 1;
	localparam int B_SMOOTH    = 0;
	localparam int B_CTRL_LOAD = 0;

	// =====================================================================
	// load sequencer
	// =====================================================================
	typedef enum logic [2:0]
	{
		ST_BOOT  = 3'b001,
		ST_LOAD  = 3'b010,
		ST_READY = 3'b100
	} load_state_t;

endpackage : pack_cfg_pkg

/* src/reg_bus_if.sv */
// interface: internal register access strobes between bus front end and register bank
`timescale 1ns/1ps
interface reg_bus_if;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport front
	(
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input  rdata
	);
	modport regs
	(
		input  wr_en,
		input  rd_en,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface : reg_bus_if

/* src/ahb_reg_front.sv */
// module: ahb-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module ahb_reg_front
	import pack_cfg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	reg_bus_if.front         rbus
);
	logic        wr_pend_ff;
	logic        rd_pend_ff;
	logic [7:0]  addr_ff;
	logic        hready_ff;
	logic [31:0] hrdata_ff;
	logic        take;

	// only whole-word transfers exist on this bus; size is accepted as is
	assign take = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);

	// =====================================================================
	// address phase capture
	// =====================================================================
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= take && hwrite;
			rd_pend_ff <= take && !hwrite;
			if (take)
				addr_ff <= haddr[7:0];
		end
	end

	// reads insert one wait state so a write just before is already stored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hready_ff <= 1'b1;
			hrdata_ff <= 32'h0000_0000;
		end
		else
		begin
			hready_ff <= !(take && !hwrite);
			if (rd_pend_ff)
				hrdata_ff <= rbus.rdata;
		end
	end

	assign rbus.wr_en = wr_pend_ff;
	assign rbus.rd_en = rd_pend_ff;
	assign rbus.addr  = addr_ff;
	assign rbus.wdata = hwdata;
	assign hreadyout  = hready_ff;
	assign hrdata     = hrdata_ff;
	assign hresp      = 1'b0;

	// =====================================================================
	// checks
	// =====================================================================
	sequence read_taken;
		take && !hwrite;
	endsequence

	chk_read_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
		read_taken |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
	chk_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && hwrite) |=> hreadyout && rbus.wr_en)
		else $error("write data phase not zero wait");

endmodule : ahb_reg_front

/* src/pack_config_register_bank.sv */
// module: pack configuration register bank with stored image, boot load and field decode
//
// Behaviour
// - high bit 7 selects no-load reserve compensation
// - high bit 6 permits calibration mode entry
// - high bit 3 chooses external voltage divider
// - high bits 2..0 wake enable, threshold; 001
// - tenfold flag only reported, no internal effect
// - low bit 5 permits sleep; default one
// - low bit 4 reloads remaining on termination
// - low bit 0 selects external thermistor; default
// - second bit 7 charge-end depth update, default
// - second bit 5 voltage consistency check enable
// - second bit 1 discharge depth weighting enable
// - second bit 0 fast convergence, default one
// - third bit 6 holds charge level discharging
// - third bit 2 allows rest-mode level jump
// - third bits 1,0 rest and general smoothing
// - third bit 4 faster sampling while sleeping
// - third bit 7 enables health display
// - main word lives in subclass 64, offset 0
// - divider calibration defaults 5000, one series cell
`timescale 1ns/1ps
module pack_config_register_bank
	import pack_cfg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             config_valid,
	output logic             reserve_noload_comp,
	output logic             calibration_permit,
	output logic             divider_select,
	output logic             current_wake_enable,
	output logic             wake_threshold_hi,
	output logic             wake_threshold_lo,
	output logic             tenfold_scale_flag,
	output logic             resistance_factor_step,
	output logic             sleep_permit,
	output logic             reload_remaining_on_full,
	output logic             external_thermistor_select,
	output logic             charge_end_depth_update,
	output logic             voltage_consistency_check,
	output logic             temp_zone_charge,
	output logic             iron_phosphate_rest,
	output logic             discharge_depth_weighting,
	output logic             fast_convergence_enable,
	output logic             health_display_enable,
	output logic             charge_level_hold,
	output logic             near_end_fast_fill,
	output logic             sleep_fast_sampling,
	output logic             zero_level_lock,
	output logic             relax_jump_permit,
	output logic             relax_smooth_enable,
	output logic             soc_smooth_enable,
	output logic [15:0]      voltage_divider_cal,
	output logic [7:0]       series_cells
);
	reg_bus_if rbus ();

	logic [15:0] nv_ff [NV_WORDS];
	logic [15:0] main_ff;
	logic [15:0] second_ff;
	logic [15:0] third_ff;
	logic [15:0] divider_ff;
	logic [15:0] cells_ff;
	logic [2:0]  idx_ff;
	logic        valid_ff;
	logic        reload_ff;
	load_state_t state_ff;
	load_state_t nxt_state;
	logic [31:0] rdata_c;

	// =====================================================================
	// bus front end
	// =====================================================================
	ahb_reg_front ahb_reg_front_i
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rbus      (rbus)
	);

	// =====================================================================
	// stored image, written by software
	// =====================================================================
	// reserved positions are masked on write so they never carry a value
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			nv_ff[IDX_MAIN]    <= RST_MAIN;
			nv_ff[IDX_SECOND]  <= RST_SECOND;
			nv_ff[IDX_THIRD]   <= RST_THIRD;
			nv_ff[IDX_DIVIDER] <= RST_DIVIDER;
			nv_ff[IDX_CELLS]   <= RST_CELLS;
		end
		else if (rbus.wr_en)
		begin
			case (rbus.addr)
				ADDR_MAIN:    nv_ff[IDX_MAIN]    <= rbus.wdata[15:0] & MASK_MAIN;
				ADDR_SECOND:  nv_ff[IDX_SECOND]  <= rbus.wdata[15:0] & MASK_SECOND;
				ADDR_THIRD:   nv_ff[IDX_THIRD]   <= rbus.wdata[15:0] & MASK_THIRD;
				ADDR_DIVIDER: nv_ff[IDX_DIVIDER] <= rbus.wdata[15:0] & MASK_DIVIDER;
				ADDR_CELLS:   nv_ff[IDX_CELLS]   <= rbus.wdata[15:0] & MASK_CELLS;
				default:      ;
			endcase
		end
	end

	// reload command: a one-cycle request taken by the sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			reload_ff <= 1'b0;
		else
			reload_ff <= rbus.wr_en && (rbus.addr == ADDR_CTRL) && rbus.wdata[B_CTRL_LOAD];
	end

	// =====================================================================
	// load sequencer: copies the stored image into the live fields
	// =====================================================================
	// next state; a reload pulse seen outside ready is dropped, not queued
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_BOOT:  nxt_state = ST_LOAD;
			ST_LOAD:  nxt_state = (idx_ff == IDX_LAST) ? ST_READY : ST_LOAD;
			ST_READY: nxt_state = reload_ff ? ST_LOAD : ST_READY;
			default:  nxt_state = ST_BOOT;
		endcase
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_ff <= ST_BOOT;
		else
			state_ff <= nxt_state;
	end

	// word index walks once per load; valid stays low until the walk ends
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			idx_ff   <= IDX_MAIN;
			valid_ff <= 1'b0;
		end
		else
		begin
			if (state_ff == ST_LOAD)
				idx_ff <= (idx_ff == IDX_LAST) ? IDX_MAIN : idx_ff + 3'h1;
			valid_ff <= (nxt_state == ST_READY);
		end
	end

	// live copies change only while loading, so consumers never see a half write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			main_ff    <= RST_MAIN;
			second_ff  <= RST_SECOND;
			third_ff   <= RST_THIRD;
			divider_ff <= RST_DIVIDER;
			cells_ff   <= RST_CELLS;
		end
		else if (state_ff == ST_LOAD)
		begin
			case (idx_ff)
				IDX_MAIN:    main_ff    <= nv_ff[IDX_MAIN];
				IDX_SECOND:  second_ff  <= nv_ff[IDX_SECOND];
				IDX_THIRD:   third_ff   <= nv_ff[IDX_THIRD];
				IDX_DIVIDER: divider_ff <= nv_ff[IDX_DIVIDER];
				IDX_CELLS:   cells_ff   <= nv_ff[IDX_CELLS];
				default:     ;
			endcase
		end
	end

	// =====================================================================
	// read mux
	// =====================================================================
	// unmapped offsets and the write-only control word read as zero
	always_comb
	begin
		rdata_c = 32'h0000_0000;
		case (rbus.addr)
			ADDR_MAIN:    rdata_c = {16'h0000, nv_ff[IDX_MAIN]};
			ADDR_SECOND:  rdata_c = {16'h0000, nv_ff[IDX_SECOND]};
			ADDR_THIRD:   rdata_c = {16'h0000, nv_ff[IDX_THIRD]};
			ADDR_DIVIDER: rdata_c = {16'h0000, nv_ff[IDX_DIVIDER]};
			ADDR_CELLS:   rdata_c = {16'h0000, nv_ff[IDX_CELLS]};
			ADDR_STATUS:  rdata_c = {16'h0000, SUBCLASS_ID, 6'h00,
				state_ff == ST_LOAD, valid_ff};
			default:      rdata_c = 32'h0000_0000;
		endcase
	end
	assign rbus.rdata = rdata_c;

	// =====================================================================
	// field decode, each straight from a live flip-flop
	// =====================================================================
	assign config_valid               = valid_ff;
	// main word, high and low bytes
	assign reserve_noload_comp        = main_ff[B_RESERVE_NOLOAD_COMP];
	assign calibration_permit         = main_ff[B_CAL_PERM];
	assign divider_select             = main_ff[B_DIV_SEL];
	assign current_wake_enable        = main_ff[B_WAKE_EN];
	assign wake_threshold_hi          = main_ff[B_WAKE_HI];
	assign wake_threshold_lo          = main_ff[B_WAKE_LO];
	// the tenfold flag drives nothing inside; it is only reported outward
	assign tenfold_scale_flag         = main_ff[B_TENFOLD];
	assign resistance_factor_step     = main_ff[B_RES_STEP];
	assign sleep_permit               = main_ff[B_SLEEP];
	assign reload_remaining_on_full   = main_ff[B_RELOAD];
	assign external_thermistor_select = main_ff[B_THERM];
	// second word
	assign charge_end_depth_update    = second_ff[B_CHG_DOD];
	assign voltage_consistency_check  = second_ff[B_VCONS];
	assign temp_zone_charge           = second_ff[B_TEMP_ZONE];
	assign iron_phosphate_rest        = second_ff[B_LFP_REST];
	assign discharge_depth_weighting  = second_ff[B_DOD_WT];
	assign fast_convergence_enable    = second_ff[B_FAST_CONV];
	// third word
	assign health_display_enable      = third_ff[B_HEALTH];
	assign charge_level_hold          = third_ff[B_HOLD];
	assign near_end_fast_fill         = third_ff[B_NEAR_END];
	assign sleep_fast_sampling        = third_ff[B_SLP_FAST];
	assign zero_level_lock            = third_ff[B_LOCK_ZERO];
	assign relax_jump_permit          = third_ff[B_JUMP];
	assign relax_smooth_enable        = third_ff[B_RSMOOTH];
	assign soc_smooth_enable          = third_ff[B_SMOOTH];
	// divider calibration and cell count
	assign voltage_divider_cal        = divider_ff;
	assign series_cells               = cells_ff[7:0];

	// =====================================================================
	// checks
	// =====================================================================
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence load_walk;
		(state_ff == ST_LOAD) [*5] ##1 valid_ff;
	endsequence
	sequence reload_req;
		rbus.wr_en && rbus.addr == ADDR_CTRL && rbus.wdata[B_CTRL_LOAD] && state_ff == ST_READY;
	endsequence
	sequence walk_step;
		state_ff == ST_LOAD && idx_ff != IDX_LAST;
	endsequence
	sequence walk_end;
		state_ff == ST_LOAD && idx_ff == IDX_LAST;
	endsequence

	// anchored on the first load cycle so the release edge itself never starts an attempt
	chk_boot_load_walk: assert property (
		state_ff == ST_LOAD && $past(state_ff) == ST_BOOT |-> load_walk)
		else $error("boot load did not finish in five load cycles");
	chk_reload_walk: assert property (
		reload_req |=> valid_ff && state_ff == ST_READY ##1 load_walk)
		else $error("reload command did not rerun the load walk");
	chk_valid_low_load: assert property (
		state_ff == ST_LOAD |-> !valid_ff)
		else $error("fields marked valid while loading");
	chk_main_copied: assert property (
		state_ff == ST_LOAD && idx_ff == IDX_MAIN |=> main_ff == $past(nv_ff[IDX_MAIN]))
		else $error("main word not loaded from stored image");
	chk_second_copied: assert property (
		state_ff == ST_LOAD && idx_ff == IDX_SECOND |=> second_ff == $past(nv_ff[IDX_SECOND]))
		else $error("second word not loaded from stored image");
	chk_third_copied: assert property (
		state_ff == ST_LOAD && idx_ff == IDX_THIRD |=> third_ff == $past(nv_ff[IDX_THIRD]))
		else $error("third word not loaded from stored image");
	chk_divider_copied: assert property (
		state_ff == ST_LOAD && idx_ff == IDX_DIVIDER |=> divider_ff == $past(nv_ff[IDX_DIVIDER]))
		else $error("divider word not loaded from stored image");
	chk_main_write: assert property (
		rbus.wr_en && rbus.addr == ADDR_MAIN |=> nv_ff[IDX_MAIN] == ($past(rbus.wdata[15:0]) & MASK_MAIN))
		else $error("main word write not stored");
	chk_live_stable: assert property (
		state_ff == ST_READY && !reload_ff |=> $stable(main_ff) && $stable(tenfold_scale_flag))
		else $error("live fields changed outside a load");
	chk_status_id: assert property (
		rbus.rd_en && rbus.addr == ADDR_STATUS |-> rbus.rdata[15:8] == SUBCLASS_ID && rbus.rdata[0] == valid_ff)
		else $error("status word wrong");

	// the walk moves one word a cycle and always ends back in ready
	chk_walk_advance: assert property (
		walk_step |=> state_ff == ST_LOAD && idx_ff == $past(idx_ff) + 3'h1)
		else $error("load walk skipped or repeated a word");
	chk_walk_finish: assert property (
		walk_end |=> state_ff == ST_READY && valid_ff && idx_ff == IDX_MAIN)
		else $error("load walk did not end in ready");
	chk_valid_ready: assert property (
		valid_ff |-> state_ff == ST_READY)
		else $error("fields marked valid outside ready");
	chk_cells_copied: assert property (
		state_ff == ST_LOAD && idx_ff == IDX_CELLS |=> cells_ff == $past(nv_ff[IDX_CELLS]))
		else $error("cell count not loaded from stored image");
	chk_divider_write: assert property (
		rbus.wr_en && rbus.addr == ADDR_DIVIDER |=> nv_ff[IDX_DIVIDER] == $past(rbus.wdata[15:0]))
		else $error("divider word write not stored");

	// words are 16 bits at most, so the upper half of every read is zero
	chk_ctrl_reads_zero: assert property (
		rbus.rd_en && rbus.addr == ADDR_CTRL |-> rbus.rdata == 32'h0000_0000)
		else $error("control word read not zero");
	chk_upper_zero: assert property (
		rbus.rd_en |-> rbus.rdata[31:16] == 16'h0000)
		else $error("upper half of read data not zero");

	// reserved positions of the image never hold a one, whatever software wrote
	chk_image_masked: assert property (
		(nv_ff[IDX_MAIN] & ~MASK_MAIN) == 16'h0000 && (nv_ff[IDX_SECOND] & ~MASK_SECOND) == 16'h0000
		&& (nv_ff[IDX_THIRD] & ~MASK_THIRD) == 16'h0000 && (nv_ff[IDX_CELLS] & ~MASK_CELLS) == 16'h0000)
		else $error("reserved position of the stored image holds a one");

endmodule : pack_config_register_bank

/* testbench/pack_config_register_bank_tb.sv */
// testbench: bus-driven checks of the pack setup bank registers and decoded fields
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("BAD %s expected %h seen %h", nm, exp, got); \
		end \
	end
module pack_config_register_bank_tb
	import pack_cfg_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp;
	logic [31:0] hrdata;
	logic        config_valid, reserve_noload_comp, calibration_permit, divider_select;
	logic        current_wake_enable, wake_threshold_hi, wake_threshold_lo, tenfold_scale_flag;
	logic        resistance_factor_step, sleep_permit, reload_remaining_on_full;
	logic        external_thermistor_select, charge_end_depth_update, voltage_consistency_check;
	logic        temp_zone_charge, iron_phosphate_rest, discharge_depth_weighting;
	logic        fast_convergence_enable, health_display_enable, charge_level_hold;
	logic        near_end_fast_fill, sleep_fast_sampling, zero_level_lock, relax_jump_permit;
	logic        relax_smooth_enable, soc_smooth_enable;
	logic [15:0] voltage_divider_cal;
	logic [7:0]  series_cells;
	logic [15:0] main_live, second_live, third_live;
	int          fail_count = 0;
	int          comparisons = 0;

	// =====================================================================
	// device under test; the lone slave's ready closes the bus loop
	// =====================================================================
	pack_config_register_bank pack_config_register_bank_i
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .config_valid,
		.reserve_noload_comp, .calibration_permit, .divider_select, .current_wake_enable,
		.wake_threshold_hi, .wake_threshold_lo, .tenfold_scale_flag, .resistance_factor_step,
		.sleep_permit, .reload_remaining_on_full, .external_thermistor_select,
		.charge_end_depth_update, .voltage_consistency_check, .temp_zone_charge,
		.iron_phosphate_rest, .discharge_depth_weighting, .fast_convergence_enable,
		.health_display_enable, .charge_level_hold, .near_end_fast_fill, .sleep_fast_sampling,
		.zero_level_lock, .relax_jump_permit, .relax_smooth_enable, .soc_smooth_enable,
		.voltage_divider_cal, .series_cells
	);

	// live fields regrouped into register shape, reserved places held at zero
	assign main_live   = {reserve_noload_comp, calibration_permit, 2'b00, divider_select,
		current_wake_enable, wake_threshold_hi, wake_threshold_lo, tenfold_scale_flag,
		resistance_factor_step, sleep_permit, reload_remaining_on_full, 3'b000,
		external_thermistor_select};
	assign second_live = {8'h00, charge_end_depth_update, 1'b0, voltage_consistency_check, 1'b0,
		temp_zone_charge, iron_phosphate_rest, discharge_depth_weighting, fast_convergence_enable};
	assign third_live  = {8'h00, health_display_enable, charge_level_hold, near_end_fast_fill,
		sleep_fast_sampling, zero_level_lock, relax_jump_permit, relax_smooth_enable,
		soc_smooth_enable};

	// =====================================================================
	// clock and watchdog
	// =====================================================================
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// about 130 cycles are expected; this span leaves wide margin
	initial
	begin
		#100us;
		fail_count++;
		stop_test();
	end

	// =====================================================================
	// bus tasks
	// =====================================================================
	// one single transfer; bounded waits so a stuck ready cannot hang silently
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		if (n >= 50)
			fail_count++;
		`CHK("response", 1'b0, hresp)
	endtask : bus_xfer

	task automatic bus_write(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] dummy;
		bus_xfer(1'b1, a, wd, dummy);
	endtask : bus_write

	task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		bus_xfer(1'b0, a, 32'h00000000, got);
		`CHK("read data", exp, got)
	endtask : read_check

	// count edges until the live copy is valid again
	task automatic wait_valid(input int exp);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			#1;
			n++;
		end
		while (config_valid !== 1'b1 && n < 20);
		`CHK("load cycles", exp, n)
	endtask : wait_valid

	task automatic check_fields(input logic [15:0] m, s, t, d, c);
		`CHK("main fields", m & MASK_MAIN, main_live)
		`CHK("second fields", s & MASK_SECOND, second_live)
		`CHK("third fields", t & MASK_THIRD, third_live)
		`CHK("divider cal", d, voltage_divider_cal)
		`CHK("series cells", c[7:0], series_cells)
	endtask : check_fields

	task automatic stop_test();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// =====================================================================
	// main sequence
	// =====================================================================
	logic [7:0]  addrs [5] = '{ADDR_MAIN, ADDR_SECOND, ADDR_THIRD, ADDR_DIVIDER, ADDR_CELLS};
	logic [15:0] masks [5] = '{MASK_MAIN, MASK_SECOND, MASK_THIRD, MASK_DIVIDER, MASK_CELLS};
	logic [31:0] pats  [2] = '{32'hffffffff, 32'h12345a5a};
	logic [7:0]  raddr [8] = '{ADDR_MAIN, ADDR_SECOND, ADDR_THIRD, ADDR_DIVIDER, ADDR_CELLS,
		ADDR_CTRL, ADDR_STATUS, 8'h1c};
	logic [31:0] rexp  [8] = '{32'h0131, 32'h00a3, 32'h0000, 32'h1388, 32'h0001, 32'h0000,
		32'h4001, 32'h0000};

	initial
	begin
		hresetn = 1'b0;
		hsel    = 1'b0;
		haddr   = 32'h00000000;
		htrans  = 2'b00;
		hwrite  = 1'b0;
		hsize   = 3'b010;
		hwdata  = 32'h00000000;
		repeat (5) @(posedge hclk);
		#1;
		check_fields(RST_MAIN, RST_SECOND, RST_THIRD, RST_DIVIDER, RST_CELLS);
		`CHK("valid in reset", 1'b0, config_valid)
		@(posedge hclk);
		hresetn <= 1'b1;
		wait_valid(6);
		check_fields(RST_MAIN, RST_SECOND, RST_THIRD, RST_DIVIDER, RST_CELLS);
		// reset image, write-only control, status with subclass, unmapped hole
		for (int i = 0; i < 8; i++)
			read_check(raddr[i], rexp[i]);
		for (int p = 0; p < 2; p++)
		begin
			// image writes land at once but leave the live fields alone
			for (int i = 0; i < 5; i++)
				bus_write(addrs[i], {16'h0000, pats[p][15:0] & masks[i]});
			bus_write(8'h1c, pats[p]);
			for (int i = 0; i < 5; i++)
				read_check(addrs[i], {16'h0000, pats[p][15:0] & masks[i]});
			read_check(8'h1c, 32'h00000000);
			if (p == 0)
				check_fields(RST_MAIN, RST_SECOND, RST_THIRD, RST_DIVIDER, RST_CELLS);
			else
				check_fields(16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
			// second reload request lands mid-load and must be ignored
			bus_write(ADDR_CTRL, 32'h00000001);
			bus_write(ADDR_CTRL, 32'h00000001);
			// the walk starts one edge after the first control write's data edge, one edge before this
			wait_valid(4);
			check_fields(pats[p][15:0], pats[p][15:0], pats[p][15:0], pats[p][15:0],
				pats[p][15:0] & MASK_CELLS);
			repeat (10) @(posedge hclk);
			#1;
			`CHK("valid holds", 1'b1, config_valid)
		end
		stop_test();
	end
endmodule : pack_config_register_bank_tb
